// *** design/rtc_regs_pkg.sv ***
// Package with register map, field positions and shared types of the RTC block
package rtc_regs_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_DEVICE_STATUS      = 8'h03;
    localparam logic [7:0] ADDR_SOFT_RESET_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_SECONDS_COUNT      = 8'h08;
    localparam logic [7:0] ADDR_MINUTES_COUNT      = 8'h09;

    // Field positions
    localparam int NVM_BUSY_BIT       = 7;
    localparam int POWERUP_BIT        = 5;
    localparam int RESET_ORIGIN_BIT   = 4;
    localparam int LOW_SUPPLY_TWO_BIT = 3;
    localparam int LOW_SUPPLY_ONE_BIT = 2;
    localparam int SOFT_RESET_BIT     = 4;

    // Values
    localparam logic [7:0] READ_ZERO     = 8'h00;
    localparam logic [3:0] BCD_NINE      = 4'h9;
    localparam logic [2:0] BCD_FIVE      = 3'h5;
    localparam logic [3:0] BCD_ZERO      = 4'h0;
    localparam logic [2:0] TENS_ZERO     = 3'h0;

    // One BCD count value 0..59
    typedef struct packed {
        logic [2:0] tens;
        logic [3:0] units;
    } bcd60_type;

    // Host register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Soft reset sequencer states, one bit changes per step except SR_RESTART to SR_IDLE
    typedef enum logic [1:0] {
        SR_IDLE    = 2'b00,
        SR_RESET   = 2'b01,
        SR_RESTART = 2'b11
    } soft_reset_state_type;

endpackage

// *** design/rtc_status_reset_and_time_regs.sv ***
// RTC status, soft reset control and seconds/minutes registers
`timescale 1ns/1ps

module rtc_status_reset_and_time_regs (
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_i,
    // Host register access
    input  wire rtc_regs_pkg::reg_req_type  req_i,
    output logic [7:0]                      rdata_o,
    // Watch tick and status sources
    input  wire logic                       tick_1hz_i,
    input  wire logic                       nvm_transfer_i,
    input  wire logic                       nvm_refresh_i,
    input  wire logic                       low_supply_level_two_flag_i,
    input  wire logic                       low_supply_level_one_flag_i,
    // System reset of the logic
    output logic                            system_reset_o
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic rtc_regs_pkg::bcd60_type bcd_inc(
        input rtc_regs_pkg::bcd60_type v);
        rtc_regs_pkg::bcd60_type r;
        r = v;
        if (v.units == rtc_regs_pkg::BCD_NINE) begin
            r.units = rtc_regs_pkg::BCD_ZERO;
            if (v.tens == rtc_regs_pkg::BCD_FIVE) begin
                r.tens = rtc_regs_pkg::TENS_ZERO;
            end else begin
                r.tens = v.tens + 3'h1;
            end
        end else begin
            r.units = v.units + 4'h1;
        end
        return r;
    endfunction

    function automatic logic is_wrap(input rtc_regs_pkg::bcd60_type v);
        return (v.tens == rtc_regs_pkg::BCD_FIVE) &&
               (v.units == rtc_regs_pkg::BCD_NINE);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    rtc_regs_pkg::soft_reset_state_type sr_state_q;
    rtc_regs_pkg::soft_reset_state_type sr_state_d;
    logic                               soft_reset_trigger_q;
    logic                               soft_reset_trigger_d;
    logic                               reset_origin_flag_q;
    logic                               reset_origin_flag_d;
    logic                               powerup_flag_q;
    logic                               powerup_flag_d;
    rtc_regs_pkg::bcd60_type            seconds_q;
    rtc_regs_pkg::bcd60_type            seconds_d;
    rtc_regs_pkg::bcd60_type            minutes_q;
    rtc_regs_pkg::bcd60_type            minutes_d;
    logic [7:0]                         rdata_q;
    logic [7:0]                         rdata_d;
    logic                               sysrst_q;
    logic                               sysrst_d;

    logic wr_status;
    logic wr_reset;
    logic wr_sec;
    logic wr_min;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    always_comb begin
        wr_status = 1'b0;
        wr_reset  = 1'b0;
        wr_sec    = 1'b0;
        wr_min    = 1'b0;
        if (req_i.addr == rtc_regs_pkg::ADDR_DEVICE_STATUS) begin
            wr_status = req_i.wr;
        end else if (req_i.addr == rtc_regs_pkg::ADDR_SOFT_RESET_CONTROL) begin
            wr_reset = req_i.wr;
        end else if (req_i.addr == rtc_regs_pkg::ADDR_SECONDS_COUNT) begin
            wr_sec = req_i.wr;
        end else if (req_i.addr == rtc_regs_pkg::ADDR_MINUTES_COUNT) begin
            wr_min = req_i.wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft reset sequencer and status flags

    always_comb begin
        sr_state_d           = sr_state_q;
        soft_reset_trigger_d = soft_reset_trigger_q;
        reset_origin_flag_d  = reset_origin_flag_q;
        powerup_flag_d       = powerup_flag_q;
        sysrst_d             = 1'b0;
        // Host may clear the origin flags by writing zero
        if (wr_status) begin
            if (!req_i.wdata[rtc_regs_pkg::POWERUP_BIT]) begin
                powerup_flag_d = 1'b0;
            end
            if (!req_i.wdata[rtc_regs_pkg::RESET_ORIGIN_BIT]) begin
                reset_origin_flag_d = 1'b0;
            end
        end
        case (sr_state_q)
            rtc_regs_pkg::SR_IDLE: begin
                // A trigger while a sequence runs is ignored
                if (wr_reset &&
                    req_i.wdata[rtc_regs_pkg::SOFT_RESET_BIT]) begin
                    soft_reset_trigger_d = 1'b1;
                    sr_state_d           = rtc_regs_pkg::SR_RESET;
                end
            end
            rtc_regs_pkg::SR_RESET: begin
                // One-cycle pulse; the time chain clears in this cycle
                sysrst_d   = 1'b1;
                sr_state_d = rtc_regs_pkg::SR_RESTART;
            end
            default: begin
                // Set after restart wins over a host clear in the same cycle
                soft_reset_trigger_d = 1'b0;
                reset_origin_flag_d  = 1'b1;
                sr_state_d           = rtc_regs_pkg::SR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Timekeeping chain

    always_comb begin
        seconds_d = seconds_q;
        minutes_d = minutes_q;
        if (sr_state_q == rtc_regs_pkg::SR_RESET) begin
            // System reset restarts the time chain
            seconds_d = '0;
            minutes_d = '0;
        end else begin
            if (tick_1hz_i) begin
                seconds_d = bcd_inc(seconds_q);
                if (is_wrap(seconds_q)) begin
                    minutes_d = bcd_inc(minutes_q);
                end
            end
            // Host write wins over the tick; stored as written, BCD
            // No range check: the host must write valid digits
            if (wr_sec) begin
                seconds_d = req_i.wdata[6:0];
            end
            if (wr_min) begin
                minutes_d = req_i.wdata[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rdata_d = rtc_regs_pkg::READ_ZERO;
        if (req_i.rd) begin
            if (req_i.addr == rtc_regs_pkg::ADDR_DEVICE_STATUS) begin
                // Busy is a live view of the sources, not a stored flag
                rdata_d[rtc_regs_pkg::NVM_BUSY_BIT] =
                    nvm_transfer_i | nvm_refresh_i;
                rdata_d[rtc_regs_pkg::POWERUP_BIT]      = powerup_flag_q;
                rdata_d[rtc_regs_pkg::RESET_ORIGIN_BIT] = reset_origin_flag_q;
                rdata_d[rtc_regs_pkg::LOW_SUPPLY_TWO_BIT] =
                    low_supply_level_two_flag_i;
                rdata_d[rtc_regs_pkg::LOW_SUPPLY_ONE_BIT] =
                    low_supply_level_one_flag_i;
            end else if (req_i.addr ==
                         rtc_regs_pkg::ADDR_SOFT_RESET_CONTROL) begin
                rdata_d[rtc_regs_pkg::SOFT_RESET_BIT] = soft_reset_trigger_q;
            end else if (req_i.addr == rtc_regs_pkg::ADDR_SECONDS_COUNT) begin
                rdata_d[6:0] = seconds_q;
            end else if (req_i.addr == rtc_regs_pkg::ADDR_MINUTES_COUNT) begin
                rdata_d[6:0] = minutes_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            // Only power-on reset sets the powerup flag; soft reset does not
            sr_state_q           <= rtc_regs_pkg::SR_IDLE;
            soft_reset_trigger_q <= 1'b0;
            reset_origin_flag_q  <= 1'b0;
            powerup_flag_q       <= 1'b1;
            seconds_q            <= '0;
            minutes_q            <= '0;
            rdata_q              <= rtc_regs_pkg::READ_ZERO;
            sysrst_q             <= 1'b0;
        end else begin
            sr_state_q           <= sr_state_d;
            soft_reset_trigger_q <= soft_reset_trigger_d;
            reset_origin_flag_q  <= reset_origin_flag_d;
            powerup_flag_q       <= powerup_flag_d;
            seconds_q            <= seconds_d;
            minutes_q            <= minutes_d;
            rdata_q              <= rdata_d;
            sysrst_q             <= sysrst_d;
        end
    end

    assign rdata_o        = rdata_q;
    assign system_reset_o = sysrst_q;

endmodule // rtc_status_reset_and_time_regs

// *** testbench/rtc_regs_sva.sv ***
// Port checker for the RTC status, reset and time registers
`timescale 1ns/1ps
module rtc_regs_sva (
    // Clock and reset
    input wire logic                      clk_sys_i,
    input wire logic                      rst_i,
    // Host access and sources
    input wire rtc_regs_pkg::reg_req_type req_i,
    input wire logic [7:0]                rdata_o,
    input wire logic                      nvm_transfer_i,
    input wire logic                      nvm_refresh_i,
    input wire logic                      system_reset_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire logic rd3 = req_i.rd && req_i.addr == 8'h03;
    wire logic rd4 = req_i.rd && req_i.addr == 8'h04;
    wire logic trig = req_i.wr && req_i.addr == 8'h04 && req_i.wdata[4];
    // Bits that must read zero at the addressed register
    wire logic [7:0] hide = req_i.addr == 8'h03 ? 8'h43 :
        req_i.addr == 8'h04 ? 8'hEF :
        req_i.addr[7:1] == 7'h04 ? 8'h80 : 8'hFF;
    sequence s_fire;
        system_reset_o ##1 !system_reset_o;
    endsequence
    a_busy_shown: assert property (rd3 && $stable(nvm_transfer_i) &&
        $stable(nvm_refresh_i) |=>
        rdata_o[7] == $past(nvm_transfer_i || nvm_refresh_i))
        else $error("busy flag wrong");
    // A trigger during a running sequence is refused, so exclude it
    a_trigger_fires: assert property (trig && !system_reset_o &&
        !$past(system_reset_o) && !$past(trig) |-> ##2 s_fire)
        else $error("soft reset pulse missing");
    a_reset_cause: assert property (system_reset_o |->
        $past(trig, 2)) else $error("unrequested system reset");
    a_origin_set: assert property (system_reset_o ##[2:8] rd3 |=>
        rdata_o[4]) else $error("reset origin not set");
    a_trigger_clear: assert property (system_reset_o ##[2:8] rd4 |=>
        rdata_o == 8'h00) else $error("trigger not cleared");
    a_unused_zero: assert property ($past(req_i.rd) |->
        (rdata_o & $past(hide)) == 8'h00) else $error("unused bit set");
    a_idle_zero: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
        else $error("read data without read");
    a_bcd_digits: assert property ($past(req_i.rd &&
        req_i.addr[7:1] == 7'h04) |-> rdata_o[3:0] <= 4'h9 &&
        rdata_o[6:4] <= 3'h5) else $error("time digit out of range");
endmodule // rtc_regs_sva
bind rtc_status_reset_and_time_regs rtc_regs_sva chk (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .nvm_transfer_i(nvm_transfer_i), .nvm_refresh_i(nvm_refresh_i),
    .system_reset_o(system_reset_o));

// *** testbench/rtc_host_model.sv ***
// Host processor model issuing register reads and writes
`timescale 1ns/1ps
module rtc_host_model (
    // Clock and read data
    input  wire logic                 clk_sys_i,
    input  wire logic [7:0]           rdata_i,
    // Request to the device
    output rtc_regs_pkg::reg_req_type req_o
);
    initial req_o = '0;
    // One-cycle strobe, dropped on the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys_i);
        req_o <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_i);
        req_o <= '0;
        #1 d = rdata_i;
    endtask
endmodule // rtc_host_model

// *** testbench/test_rtc_status_reset_and_time_regs.sv ***
// Self-checking testbench for the RTC register block
`timescale 1ns/1ps
module test_rtc_status_reset_and_time_regs;
    logic                      clk_sys_i = 1'b0;
    logic                      rst_i = 1'b1;
    rtc_regs_pkg::reg_req_type req;
    logic [7:0]                rdata;
    logic [7:0]                v;
    logic                      tick = 1'b0;
    logic                      xfer = 1'b0;
    logic                      refr = 1'b0;
    logic                      lv2 = 1'b1;
    logic                      lv1 = 1'b0;
    logic                      sysrst;
    int                        n_resets = 0;
    int                        err_total = 0;
    int                        n_checks = 0;
    int                        cyc = 0;
    initial forever #50 clk_sys_i = ~clk_sys_i;
    rtc_status_reset_and_time_regs uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .req_i(req), .rdata_o(rdata), .tick_1hz_i(tick),
        .nvm_transfer_i(xfer), .nvm_refresh_i(refr),
        .low_supply_level_two_flag_i(lv2), .low_supply_level_one_flag_i(lv1),
        .system_reset_o(sysrst));
    rtc_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, v);
        chk(v, exp);
    endtask
    task automatic pulse;
        @(posedge clk_sys_i);
        tick <= 1'b1;
        @(posedge clk_sys_i);
        tick <= 1'b0;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Whole sequence needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        // Counts high cycles of the soft reset pulse
        if (sysrst === 1'b1)
            n_resets++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rchk(8'h03, 8'h28);
        @(posedge clk_sys_i);
        xfer <= 1'b1;
        lv2 <= 1'b0;
        lv1 <= 1'b1;
        rchk(8'h03, 8'hA4);
        @(posedge clk_sys_i);
        xfer <= 1'b0;
        refr <= 1'b1;
        rchk(8'h03, 8'hA4);
        @(posedge clk_sys_i);
        refr <= 1'b0;
        lv1 <= 1'b0;
        host.wr(8'h03, 8'hCF);
        rchk(8'h03, 8'h00);
        host.wr(8'h08, 8'hD9);
        host.wr(8'h09, 8'h58);
        rchk(8'h08, 8'h59);
        pulse();
        rchk(8'h08, 8'h00);
        rchk(8'h09, 8'h59);
        host.wr(8'h08, 8'h09);
        pulse();
        rchk(8'h08, 8'h10);
        host.wr(8'h04, 8'hEF);
        repeat (3) @(posedge clk_sys_i);
        rchk(8'h08, 8'h10);
        rchk(8'h04, 8'h00);
        host.wr(8'h04, 8'h10);
        rchk(8'h04, 8'h10);
        repeat (3) @(posedge clk_sys_i);
        rchk(8'h04, 8'h00);
        rchk(8'h03, 8'h10);
        rchk(8'h09, 8'h00);
        rchk(8'h05, 8'h00);
        chk(8'(n_resets), 8'h01);
        // Power-on reset again in mid-run
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rchk(8'h03, 8'h20);
        rchk(8'h08, 8'h00);
        final_report();
    end
endmodule // test_rtc_status_reset_and_time_regs
